// file: inc/adc_start_consts.svh
`ifndef ADC_START_CONSTS_SVH
`define ADC_START_CONSTS_SVH
// Word offsets on the Avalon-MM bus (byte address = 4 * index)
`define OFS_CTRL0      3'h0
`define OFS_CTRL1      3'h1
`define OFS_TRIG_SEL   3'h2
`define OFS_MODE0      3'h3
`define OFS_MODE1      3'h4
`define OFS_STATUS     3'h5
// Control register fields
`define CTRL_GATE_BIT  7
`define CTRL_GO_BIT    4
`define CTRL_SCAN_BIT  3
`define CTRL_RSVD_ONES 3'h7
// Trigger select field encodings
`define TRIG_BOTH      2'h0
`define TRIG_PIN       2'h1
`define TRIG_TIMER     2'h2
`define TRIG_SEL_RESET 8'h00
// Conversion defaults: length in clock cycles, scan channel count
`define CONV_CYCLES_DEF 16'd1024
`define CHAN_COUNT_DEF  3'd4
`endif

// file: inc/adc_start_pkg.sv
package adc_start_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_e;

  typedef struct packed {
    conv_state_e state;
    logic        go;
    logic        scan_repeat;
    logic        gate;
    logic        mode_scan;
    logic [15:0] cnt;
    logic [2:0]  chan;
  } unit_s;

  typedef struct packed {
    unit_s [1:0] unit;
    logic [3:0]  trig_sel;
    logic [1:0]  pin_sync;
    logic        pin_prev;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  busy;
    logic [1:0]  done;
  } state_s;
endpackage

// file: design/adc_start_trigger_control.sv
`timescale 1ns/1ns
`include "adc_start_consts.svh"
// Notes on behaviour
// R1 - Writing go bit one starts conversion
// R2 - Clearing go bit aborts, returns idle
// R3 - Single and one-shot scan self-clear go
// R4 - Continuous scan repeats until go cleared
// R5 - Scan-repeat bit matters only in scan
// R6 - Control low three bits read one
// R7 - Trigger select upper nibble reads zero
// R8 - Unit one field selects pin/timer sources
// R9 - Unit zero field same encoding
// R10 - Software never writes field value 11
// R11 - Clear go and gate before field change
// R12 - Clear go before scan type change
// R13 - Gate bit enables hardware triggers
// R14 - Pin falling edge sets go bit
// R15 - Timer request sets go bit
// R16 - Mode bit selects single or scan
// R17 - Units are fully independent
module adc_start_trigger_control
  import adc_start_pkg::*;
#(
  parameter logic [15:0] CONV_CYCLES = `CONV_CYCLES_DEF,
  parameter logic [2:0]  CHAN_COUNT  = `CHAN_COUNT_DEF
)(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        external_trigger_pin_i,
  input  wire logic [1:0]  multi_timer_unit_req_i,
  output logic [1:0]       conv_busy_o,
  output logic [1:0]       conv_done_o
);

  state_s s_r;
  state_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic       pin_fall;
    logic       wr;
    logic       rd;
    logic       hw_go;
    logic [1:0] fld;
    logic       last;
    s_nxt    = s_r;
    pin_fall = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    hw_go    = 1'b0;
    fld      = 2'h0;
    last     = 1'b0;

    // Pin is asynchronous; only the second stage feeds the edge detector
    s_nxt.pin_sync = {s_r.pin_sync[0], external_trigger_pin_i};
    s_nxt.pin_prev = s_r.pin_sync[1];
    pin_fall = s_r.pin_prev & ~s_r.pin_sync[1]; // R14

    // One wait cycle per access keeps read data registered
    wr = avs_write_i & s_r.waitreq & avs_byteenable_i[0];
    rd = avs_read_i & s_r.waitreq;
    s_nxt.waitreq = ~((avs_read_i | avs_write_i) & s_r.waitreq);

    if (wr && avs_address_i == `OFS_TRIG_SEL)
    begin
      s_nxt.trig_sel = avs_writedata_i[3:0];
    end

    s_nxt.done = 2'b00;
    for (int u = 0; u < 2; u++)
    begin
      // R17
      fld = s_r.trig_sel[2*u +: 2]; // R8 R9
      hw_go = 1'b0;
      if (s_r.unit[u].gate) // R13
      begin
        case (fld)
          `TRIG_BOTH:  hw_go = pin_fall | multi_timer_unit_req_i[u];
          `TRIG_PIN:   hw_go = pin_fall; // R14
          `TRIG_TIMER: hw_go = multi_timer_unit_req_i[u]; // R15
          default:     hw_go = 1'b0; // Undefined setting starts nothing
        endcase
      end

      last = (s_r.unit[u].cnt == CONV_CYCLES - 16'd1);

      // Conversion engine
      case (s_r.unit[u].state)
        ST_IDLE:
        begin
          s_nxt.unit[u].cnt  = 16'h0000;
          s_nxt.unit[u].chan = 3'h0;
          if (s_r.unit[u].go)
          begin
            s_nxt.unit[u].state = ST_CONV; // R1
          end
        end
        ST_CONV:
        begin
          if (!s_r.unit[u].go)
          begin
            s_nxt.unit[u].state = ST_IDLE; // R2
          end
          else if (last)
          begin
            s_nxt.unit[u].cnt = 16'h0000;
            if (!s_r.unit[u].mode_scan || s_r.unit[u].chan == CHAN_COUNT - 3'd1) // R16
            begin
              s_nxt.done[u] = 1'b1;
              s_nxt.unit[u].chan = 3'h0;
              if (!(s_r.unit[u].mode_scan && s_r.unit[u].scan_repeat)) // R5
              begin
                s_nxt.unit[u].go    = 1'b0; // R3
                s_nxt.unit[u].state = ST_IDLE;
              end
              // Otherwise loop back to first channel R4
            end
            else
            begin
              s_nxt.unit[u].chan = s_r.unit[u].chan + 3'd1;
            end
          end
          else
          begin
            s_nxt.unit[u].cnt = s_r.unit[u].cnt + 16'd1;
          end
        end
        default: s_nxt.unit[u].state = ST_IDLE;
      endcase

      // Software write wins over self-clear; hardware start wins over both
      if (wr && avs_address_i == 3'(`OFS_CTRL0 + u))
      begin
        s_nxt.unit[u].gate        = avs_writedata_i[`CTRL_GATE_BIT];
        s_nxt.unit[u].go          = avs_writedata_i[`CTRL_GO_BIT]; // R1 R2
        s_nxt.unit[u].scan_repeat = avs_writedata_i[`CTRL_SCAN_BIT];
      end
      if (wr && avs_address_i == 3'(`OFS_MODE0 + u))
      begin
        s_nxt.unit[u].mode_scan = avs_writedata_i[0]; // R16
      end
      if (hw_go)
      begin
        s_nxt.unit[u].go = 1'b1; // R14 R15
      end
      s_nxt.busy[u] = (s_nxt.unit[u].state == ST_CONV);
    end

    // Read mux; unmapped words read zero
    if (rd)
    begin
      case (avs_address_i)
        `OFS_CTRL0, `OFS_CTRL1:
          s_nxt.rdata = {24'h0, s_r.unit[avs_address_i[0]].gate, 2'b00,
                         s_r.unit[avs_address_i[0]].go,
                         s_r.unit[avs_address_i[0]].scan_repeat, `CTRL_RSVD_ONES}; // R6
        `OFS_TRIG_SEL: s_nxt.rdata = {28'h0, s_r.trig_sel}; // R7
        `OFS_MODE0:    s_nxt.rdata = {31'h0, s_r.unit[0].mode_scan};
        `OFS_MODE1:    s_nxt.rdata = {31'h0, s_r.unit[1].mode_scan};
        `OFS_STATUS:   s_nxt.rdata = {30'h0, s_r.busy};
        default:       s_nxt.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_r          <= '0;
      s_r.waitreq  <= 1'b1;
      s_r.trig_sel <= 4'(`TRIG_SEL_RESET);
      s_r.pin_sync <= 2'b11;
      s_r.pin_prev <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata_o    = s_r.rdata;
  assign avs_waitrequest_o = s_r.waitreq;
  assign conv_busy_o       = s_r.busy;
  assign conv_done_o       = s_r.done;

endmodule

// file: tb/trig_model.sv
`timescale 1ns/1ns
module trig_model (
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] fire_i,
  output logic            pin_o,
  output logic [1:0]      tmr_o = 2'h0
);
  logic [2:0] low_r = 3'h0;
  // Pin idles high, as with a pull-up
  assign pin_o = (low_r == 3'h0);
  always @(posedge ref_clk_i)
  begin
    low_r <= fire_i[2] ? 3'h4 : low_r - {2'h0, |low_r};
    tmr_o <= fire_i[1:0];
  end
endmodule

// file: tb/adc_start_monitor.sv
`timescale 1ns/1ns
module adc_start_monitor #(
  parameter logic [15:0] CONV_CYCLES = 16'h4,
  parameter logic [2:0]  CHAN_COUNT  = 3'h4
)(
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  conv_busy_o,
  input wire logic [1:0]  conv_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire req = avs_read_i | avs_write_i;
  sequence req_s;
    $rose(req);
  endsequence
  ack_next_a: assert property (req_s |=> !avs_waitrequest_o)
    else $error("late ack");
  ack_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("long ack");
  idle_wait_a: assert property (!req |=> avs_waitrequest_o)
    else $error("stray ack");
  rdata_hold_a: assert property (!avs_read_i [*2] |-> $stable(avs_readdata_o))
    else $error("rdata moved");
  done_pulse_a: assert property (conv_done_o[0] |=> !conv_done_o[0])
    else $error("long done");
  done_busy_a: assert property (|conv_done_o |-> !(conv_done_o & ~$past(conv_busy_o)))
    else $error("done idle");
  busy0_hold_a: assert property ($rose(conv_busy_o[0]) && !avs_write_i |=> conv_busy_o[0])
    else $error("short busy");
  busy1_hold_a: assert property ($rose(conv_busy_o[1]) && !avs_write_i |=> conv_busy_o[1])
    else $error("short busy");
endmodule
bind adc_start_trigger_control adc_start_monitor
  #(.CONV_CYCLES(CONV_CYCLES), .CHAN_COUNT(CHAN_COUNT)) u_mon (.*);

// file: tb/adc_start_trigger_control_test.sv
`timescale 1ns/1ns
`include "adc_start_consts.svh"
module adc_start_trigger_control_test;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [2:0]  avs_address_i = 3'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        external_trigger_pin_i;
  logic [1:0]  multi_timer_unit_req_i, conv_busy_o, conv_done_o;
  logic [2:0]  fire = 3'h0;
  logic [15:0] lfsr = 16'hbed8;
  logic [7:0]  q;
  int          mismatches = 0;
  int          tests_run = 0;
  // Short conversions keep the run small
  adc_start_trigger_control #(.CONV_CYCLES(16'h4)) i_dut (.*);
  trig_model u_trig (.ref_clk_i(ref_clk_i), .fire_i(fire), .pin_o(external_trigger_pin_i),
    .tmr_o(multi_timer_unit_req_i));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] ctrl(input logic go, scan, gate);
    return {gate, 2'h0, go, scan, 3'h7};
  endfunction
  // Repeatable pseudo-random source; the seed is fixed
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Random upper data and byte enables must be ignored
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    lfsr = lfsr_next(lfsr);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= {lfsr, 8'h00, d};
    avs_byteenable_i <= {lfsr[2:0], 1'b1};
    do
      @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wd(input int u);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (conv_done_o[u] !== 1'b1 && n < 200);
    chk(conv_done_o[u], 1'b1);
  endtask
  // A start that ends quickly still shows in the accumulated busy
  task automatic idle;
    logic [1:0] seen;
    seen = 2'h0;
    repeat (30)
    begin
      @(posedge ref_clk_i);
      seen = seen | conv_busy_o;
    end
    chk(seen, 2'h0);
  endtask
  task automatic go(input logic [2:0] f);
    repeat (lfsr[2:0]) @(posedge ref_clk_i);
    fire <= f;
    @(posedge ref_clk_i);
    fire <= 3'h0;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    bus(0, `OFS_CTRL0, 8'h00);
    chk(q, ctrl(0, 0, 0));
    bus(1, `OFS_TRIG_SEL, 8'h09);
    bus(0, `OFS_TRIG_SEL, 8'h00);
    chk(q, 8'h09);
    bus(1, `OFS_CTRL0, ctrl(1, 1, 0));
    wd(0);
    bus(0, `OFS_CTRL0, 8'h00);
    chk(q, ctrl(0, 1, 0));
    bus(1, `OFS_MODE0, 8'h01);
    bus(1, `OFS_CTRL0, ctrl(1, 1, 0));
    wd(0);
    wd(0);
    bus(0, `OFS_CTRL0, 8'h00);
    chk(q, ctrl(1, 1, 0));
    bus(1, `OFS_CTRL0, ctrl(0, 1, 0));
    repeat (3) @(posedge ref_clk_i);
    chk(conv_busy_o, 2'h0);
    bus(1, `OFS_CTRL0, ctrl(1, 0, 0));
    wd(0);
    bus(0, `OFS_CTRL0, 8'h00);
    chk(q, ctrl(0, 0, 0));
    bus(1, `OFS_CTRL0, ctrl(0, 0, 1));
    bus(1, `OFS_CTRL1, ctrl(0, 0, 1));
    go(3'h1);
    idle;
    go(3'h4);
    wd(0);
    chk(conv_busy_o[1], 1'b0);
    go(3'h2);
    wd(1);
    bus(1, `OFS_CTRL1, ctrl(0, 0, 0));
    go(3'h2);
    idle;
    report_and_stop;
  end
endmodule
